// ---- dma_flag_map.vh ----
`ifndef DMA_FLAG_MAP_VH
`define DMA_FLAG_MAP_VH
// Register offsets (byte addresses on the register port)
`define STATUS_OFFSET      8'h00
`define CLEAR_OFFSET       8'h04
`define IRQ_ENABLE_OFFSET  8'h08
`define IRQ_CLEAR_OFFSET   8'h0c
`define IRQ_STATUS_OFFSET  8'h10
// Field positions inside a four-bit channel group, channel count, reserved bits of the word
`define SUMMARY_BIT        0
`define DONE_BIT           1
`define HALF_BIT           2
`define ERROR_BIT          3
`define CHANNEL_COUNT      7
`define RESERVED_MSB       31
`define RESERVED_LSB       28
// Reset values
`define STATUS_RESET       32'h0000_0000
`define IRQ_ENABLE_RESET   3'h0
`define IRQ_STATUS_RESET   3'h0
`endif

// ---- dma_event_flag_clear.v ----
`timescale 1ns/100ps
`include "dma_flag_map.vh"
// Notes on behaviour
// R01: Writing 1 at bit 4(n-1)+3 clears channel n's error flag; 0 no effect.
// R02: Writing 1 at bit 4(n-1)+2 clears channel n's half flag; 0 no effect.
// R03: Writing 1 at bit 4(n-1)+1 clears channel n's done flag; 0 no effect.
// R04: Writing 1 at bit 4(n-1) clears all four flags of channel n.
// R05: Bits 31..28 reserved, no function; all clear bits reset to zero.
// R06: Summary flag is set whenever any of the channel's three flags is set.
// R07: Event flags read-only; cleared only via clear register; read 1 after event.
// R08: Clear register reads zero; bits 11 and 10 act on channel 3.
module dma_event_flag_clear (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire [7:0]  addr_in,
    input  wire [31:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    input  wire [6:0]  error_event_in,
    input  wire [6:0]  half_event_in,
    input  wire [6:0]  done_event_in,
    output reg  [31:0] rdata_out,
    output reg  [31:0] event_status_out,
    output reg         irq_out
);
    // Seven channels of four flags each; the top status nibble is unused.
    // A clear acts in the cycle of its write; nothing is buffered.
    // Limitation: the clear register stores nothing, so it always reads zero.
    // Trade-off: one flat status word instead of per-channel registers keeps
    // reads to a single access, at the cost of a wide read multiplexer.

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [31:0] status_reg;
    reg  [31:0] status_next;
    reg  [2:0]  irq_status_reg;
    reg  [2:0]  irq_status_next;
    reg  [2:0]  irq_enable_reg;
    reg  [31:0] rdata_next;
    wire        status_sel;
    wire        clear_sel;
    wire        enable_sel;
    wire        irq_clear_sel;
    wire        irq_status_sel;
    wire        clear_hit;
    wire        irq_clear_hit;
    wire [31:0] clear_word;
    wire [27:0] group_now;
    wire [27:0] group_next;
    wire [2:0]  irq_raise;

    // ****************************************************************
    // Register port decode
    // ****************************************************************
    // Offsets are compared in full; unmapped addresses select nothing
    assign status_sel     = (addr_in == `STATUS_OFFSET);
    assign clear_sel      = (addr_in == `CLEAR_OFFSET);
    assign enable_sel     = (addr_in == `IRQ_ENABLE_OFFSET);
    assign irq_clear_sel  = (addr_in == `IRQ_CLEAR_OFFSET);
    assign irq_status_sel = (addr_in == `IRQ_STATUS_OFFSET);

    // Write-side strobes; a read to these offsets has no side effect
    assign clear_hit      = wr_in && clear_sel;
    assign irq_clear_hit  = wr_in && irq_clear_sel;

    // ****************************************************************
    // Clear word
    // ****************************************************************
    // Reserved bits masked so they can never act on anything
    assign clear_word = clear_hit ? {4'h0, wdata_in[`RESERVED_LSB-1:0]} : 32'h0; // R05

    // Only the seven groups are fed back; the reserved nibble is rebuilt
    assign group_now  = status_reg[`RESERVED_LSB-1:0];

    // ****************************************************************
    // Per-channel flag groups, four bits each, channel 1 lowest
    // ****************************************************************
    // Channel 1: clear bits 3..0
    // Events on pulse bit 0
    channel_flag_next ch1_flags (
        .flags_in       (group_now[3:0]),
        .clear_in       (clear_word[3:0]),
        .error_event_in (error_event_in[0]),
        .half_event_in  (half_event_in[0]),
        .done_event_in  (done_event_in[0]),
        .flags_out      (group_next[3:0])
    );

    // Channel 2: clear bits 7..4
    // Events on pulse bit 1
    channel_flag_next ch2_flags (
        .flags_in       (group_now[7:4]),
        .clear_in       (clear_word[7:4]),
        .error_event_in (error_event_in[1]),
        .half_event_in  (half_event_in[1]),
        .done_event_in  (done_event_in[1]),
        .flags_out      (group_next[7:4])
    );

    // Channel 3: clear bits 11..8, bits 11 and 10 in the regular layout
    // Events on pulse bit 2
    channel_flag_next ch3_flags ( // R08
        .flags_in       (group_now[11:8]),
        .clear_in       (clear_word[11:8]),
        .error_event_in (error_event_in[2]),
        .half_event_in  (half_event_in[2]),
        .done_event_in  (done_event_in[2]),
        .flags_out      (group_next[11:8])
    );

    // Channel 4: clear bits 15..12
    // Events on pulse bit 3
    channel_flag_next ch4_flags (
        .flags_in       (group_now[15:12]),
        .clear_in       (clear_word[15:12]),
        .error_event_in (error_event_in[3]),
        .half_event_in  (half_event_in[3]),
        .done_event_in  (done_event_in[3]),
        .flags_out      (group_next[15:12])
    );

    // Channel 5: clear bits 19..16
    // Events on pulse bit 4
    channel_flag_next ch5_flags (
        .flags_in       (group_now[19:16]),
        .clear_in       (clear_word[19:16]),
        .error_event_in (error_event_in[4]),
        .half_event_in  (half_event_in[4]),
        .done_event_in  (done_event_in[4]),
        .flags_out      (group_next[19:16])
    );

    // Channel 6: clear bits 23..20
    // Events on pulse bit 5
    channel_flag_next ch6_flags (
        .flags_in       (group_now[23:20]),
        .clear_in       (clear_word[23:20]),
        .error_event_in (error_event_in[5]),
        .half_event_in  (half_event_in[5]),
        .done_event_in  (done_event_in[5]),
        .flags_out      (group_next[23:20])
    );

    // Channel 7: clear bits 27..24
    // Events on pulse bit 6
    channel_flag_next ch7_flags (
        .flags_in       (group_now[27:24]),
        .clear_in       (clear_word[27:24]),
        .error_event_in (error_event_in[6]),
        .half_event_in  (half_event_in[6]),
        .done_event_in  (done_event_in[6]),
        .flags_out      (group_next[27:24])
    );

    // Reserved nibble is forced to zero whatever was written
    always @* begin
        status_next = {4'h0, group_next}; // R05
    end

    // ****************************************************************
    // Interrupt bits: 0 error, 1 half, 2 done of any channel
    // ****************************************************************
    // Any channel's pulse raises the shared bit of its kind
    assign irq_raise = {|done_event_in, |half_event_in, |error_event_in};

    // Set after clear so a coinciding event is kept
    always @* begin
        irq_status_next = irq_status_reg;
        if (irq_clear_hit) begin
            irq_status_next = irq_status_reg & ~wdata_in[2:0];
        end
        irq_status_next = irq_status_next | irq_raise;
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Zero outside a read cycle, so stale data never lingers on the port
    always @* begin
        rdata_next = 32'h0;
        if (rd_in) begin
            if (status_sel) begin
                rdata_next = status_reg; // R07
            end else if (clear_sel) begin
                rdata_next = 32'h0; // R08
            end else if (enable_sel) begin
                rdata_next = {29'h0, irq_enable_reg};
            end else if (irq_status_sel) begin
                rdata_next = {29'h0, irq_status_reg};
            end else begin
                rdata_next = 32'h0;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Internal status; writes to it are ignored, only clears reach it
    always @(posedge clk_in) begin
        if (rst_in) begin
            status_reg <= `STATUS_RESET; // R05
        end else begin
            status_reg <= status_next; // R07
        end
    end

    // Output copy loads from the same next value, so port and reads agree
    always @(posedge clk_in) begin
        if (rst_in) begin
            event_status_out <= `STATUS_RESET; // R05
        end else begin
            event_status_out <= status_next;
        end
    end

    // Interrupt status bits
    always @(posedge clk_in) begin
        if (rst_in) begin
            irq_status_reg <= `IRQ_STATUS_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // Interrupt enable, written whole
    always @(posedge clk_in) begin
        if (rst_in) begin
            irq_enable_reg <= `IRQ_ENABLE_RESET;
        end else begin
            if (wr_in && enable_sel) begin
                irq_enable_reg <= wdata_in[2:0];
            end
        end
    end

    // Level interrupt built from next status; a new enable lags one cycle
    always @(posedge clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_status_next & irq_enable_reg);
        end
    end

    // Read data stand in the cycle after the strobe only
    always @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0;
        end else begin
            rdata_out <= rdata_next;
        end
    end
endmodule // dma_event_flag_clear

// ****************************************************************
// Next value of one channel's four flags
// ****************************************************************
// Purely combinational; the caller owns the flip-flops
module channel_flag_next (
    input  wire [3:0] flags_in,
    input  wire [3:0] clear_in,
    input  wire       error_event_in,
    input  wire       half_event_in,
    input  wire       done_event_in,
    output reg  [3:0] flags_out
);
    wire error_clear;
    wire half_clear;
    wire done_clear;

    // A group clear reaches every flag of the channel
    assign error_clear = clear_in[`ERROR_BIT] | clear_in[`SUMMARY_BIT]; // R01 R04
    assign half_clear  = clear_in[`HALF_BIT] | clear_in[`SUMMARY_BIT];  // R02 R04
    assign done_clear  = clear_in[`DONE_BIT] | clear_in[`SUMMARY_BIT];  // R03 R04

    // Clear first, then set: an event in the clearing cycle survives
    always @* begin
        flags_out = flags_in;
        if (error_clear) begin
            flags_out[`ERROR_BIT] = 1'b0;
        end
        if (half_clear) begin
            flags_out[`HALF_BIT] = 1'b0;
        end
        if (done_clear) begin
            flags_out[`DONE_BIT] = 1'b0;
        end
        if (error_event_in) begin
            flags_out[`ERROR_BIT] = 1'b1; // R07
        end
        if (half_event_in) begin
            flags_out[`HALF_BIT] = 1'b1; // R07
        end
        if (done_event_in) begin
            flags_out[`DONE_BIT] = 1'b1; // R07
        end
        // Summary is rebuilt, never stored alone, so it cannot go stale
        flags_out[`SUMMARY_BIT] = flags_out[`ERROR_BIT] | flags_out[`HALF_BIT] |
            flags_out[`DONE_BIT]; // R06
    end
endmodule // channel_flag_next

// ---- dma_event_flag_clear_properties.sv ----
`timescale 1ns/100ps
// ****
// Clear register checker
// ****
module flag_clear_chk (
    input wire clk_in, rst_in, wr_in, rd_in, irq_out,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in, rdata_out, event_status_out,
    input wire [6:0] error_event_in, half_event_in, done_event_in);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Clear bits only count on a clear write; set wins, so mask events
    wire [31:0] w = wdata_in & {32{wr_in && addr_in == 8'h04}};
    wire [31:0] s = event_status_out;
    wire [6:0] e = error_event_in, h = half_event_in, d = done_event_in;
    a_error_clear: assert property (w[3] && !e[0] |=> !s[3]) else $error("err");
    a_half_clear: assert property (w[10] && !h[2] |=> !s[10]) else $error("half");
    a_done_clear: assert property (w[25] && !d[6] |=> !s[25]) else $error("done");
    a_group_clear: assert property (w[4] && !(e[1] | h[1] | d[1]) |=> s[7:4] == 4'h0)
        else $error("group");
    a_reserved_zero: assert property (s[31:28] == 4'h0) else $error("reserved");
    a_summary_or: assert property (s[0] == |s[3:1]) else $error("summary");
    a_flag_sticky: assert property ((s[11] && !w[11] && !w[8]) || e[2] |=> s[11])
        else $error("sticky");
    a_clear_reads_zero: assert property (rd_in && addr_in == 8'h04 |=> rdata_out == 32'h0)
        else $error("readback");
    c_group: cover property (w[4]);
    c_readback: cover property (rd_in && addr_in == 8'h04);
    c_irq: cover property ($rose(irq_out));
endmodule // flag_clear_chk
bind dma_event_flag_clear flag_clear_chk chk (.*);

// ---- dma_event_flag_clear_tb_top.sv ----
`timescale 1ns/100ps
// ****
// Bench: drives the register port and event pulses
// ****
module dma_event_flag_clear_tb_top;
    reg clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    reg [7:0] addr_in = 8'h0;
    reg [31:0] wdata_in = 32'h0;
    reg [6:0] er = 7'h0, hf = 7'h0, dn = 7'h0;
    wire [31:0] rdata_out, status;
    wire irq_out;
    integer errors = 0, checks = 0;
    always #5 clk_in = ~clk_in;
    dma_event_flag_clear DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .error_event_in(er),
        .half_event_in(hf), .done_event_in(dn), .rdata_out(rdata_out),
        .event_status_out(status), .irq_out(irq_out));
    task cmp(input [63:0] n, input [31:0] x, g); begin
        checks = checks + 1;
        if (g !== x) begin
            errors = errors + 1;
            $display("CHECK FAILED %0s exp %h got %h", n, x, g);
        end
    end endtask
    task wr(input [7:0] a, input [31:0] v); begin
        @(posedge clk_in); addr_in <= a; wdata_in <= v; wr_in <= 1'b1;
        @(posedge clk_in); wr_in <= 1'b0;
    end endtask
    // Read data only stand in the cycle after the strobe
    task rd(input [7:0] a, input [31:0] x); begin
        @(posedge clk_in); addr_in <= a; rd_in <= 1'b1;
        @(posedge clk_in); rd_in <= 1'b0;
        @(negedge clk_in); cmp("rdata", x, rdata_out);
    end endtask
    task st(input [31:0] x); begin
        @(negedge clk_in); cmp("status", x, status);
    end endtask
    // Irq is registered after its cause, so allow two edges
    task iq(input x); begin
        repeat (2) @(posedge clk_in); @(negedge clk_in); cmp("irq", {31'h0, x}, {31'h0, irq_out});
    end endtask
    task ev(input [6:0] a, b, c); begin
        @(posedge clk_in); er <= a; hf <= b; dn <= c;
        @(posedge clk_in); er <= 7'h0; hf <= 7'h0; dn <= 7'h0;
    end endtask
    task t_clear; begin
        ev(7'h7f, 7'h7f, 7'h7f); rd(8'h00, 32'h0fffffff);
        wr(8'h04, 32'h8); st(32'h0ffffff7);
        wr(8'h04, 32'h6); st(32'h0ffffff0);
        wr(8'h04, 32'h10); st(32'h0fffff00);
        wr(8'h04, 32'hc00); st(32'h0ffff300);
        wr(8'h04, 32'hf2000000); st(32'h0dfff300);
        wr(8'h00, 32'hffffffff); st(32'h0dfff300);
        rd(8'h04, 32'h0); rd(8'h20, 32'h0);
        $display("t_clear done");
    end endtask
    task t_irq; begin
        rd(8'h10, 32'h7); wr(8'h08, 32'h7); iq(1'b1);
        wr(8'h0c, 32'h7); iq(1'b0);
        wr(8'h08, 32'h1); ev(7'h0, 7'h1, 7'h0); iq(1'b0);
        ev(7'h1, 7'h0, 7'h0); iq(1'b1); rd(8'h10, 32'h3);
        $display("t_irq done");
    end endtask
    // Event and clear in one cycle: the event must win
    task t_race; begin
        @(posedge clk_in);
        er <= 7'h1;
        addr_in <= 8'h04;
        wdata_in <= 32'h9;
        wr_in <= 1'b1;
        @(posedge clk_in);
        er <= 7'h0;
        wr_in <= 1'b0;
        st(32'h0dfff309);
        wr(8'h04, 32'h1); st(32'h0dfff300);
        $display("t_race done");
    end endtask
    task wrap_up; begin
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end endtask
    initial begin
        repeat (5) @(posedge clk_in); rst_in <= 1'b0;
        st(32'h0); t_clear; t_irq; t_race; wrap_up;
    end
    // Whole run needs about 50 cycles
    initial begin #20000; errors = errors + 1; wrap_up; end
endmodule // dma_event_flag_clear_tb_top
